// File: bench/udbr_assertions.sv
// concurrent checks on the data buffer block ports
module udbr_assertions (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic TX_SHIFT_EMPTY,
  input wire logic TX_LOAD,
  input wire logic [8:0] TX_DATA,
  input wire logic [7:0] CFG_ENABLE_AND_RECEIVE_MODE_CONTROL,
  input wire logic [7:0] CFG_FRAME_FORMAT_CONTROL,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic take;
  logic wtake;
  logic seen_q;
  assign take = HSEL && HTRANS[1] && HREADY;
  assign wtake = take && HWRITE;
  // low byte write seen since the last handoff
  always @(posedge CLK or negedge NRST) begin
    if (!NRST)
      seen_q <= 1'b0;
    else if (wtake && HADDR[6:2] == 5'h02)
      seen_q <= 1'b1;
    else if (TX_LOAD)
      seen_q <= 1'b0;
  end
  chk_wait_state: assert property (
    take |=> !HREADYOUT ##1 HREADYOUT) else $error("bad wait state");
  chk_load_cond: assert property (
    TX_LOAD |-> TX_SHIFT_EMPTY && CFG_ENABLE_AND_RECEIVE_MODE_CONTROL[6]) else $error("bad load");
  chk_load_single: assert property (
    TX_LOAD |=> !TX_LOAD) else $error("double load");
  chk_load_written: assert property (
    TX_LOAD |-> seen_q) else $error("load without data");
  chk_txdata_hold: assert property (
    $changed(TX_DATA) |-> $past(wtake, 2)) else $error("data moved");
  chk_spi_ninth: assert property (
    TX_LOAD && CFG_FRAME_FORMAT_CONTROL[7:6] == 2'h3 |-> !TX_DATA[8])
    else $error("ninth bit in spi");
  chk_short_char: assert property (
    TX_LOAD && CFG_FRAME_FORMAT_CONTROL[2:0] < 3'h3 |-> (TX_DATA >> (5 + CFG_FRAME_FORMAT_CONTROL[2:0]))
    == 9'h000) else $error("upper bits sent");
  chk_irq_clear: assert property (
    $fell(IRQ) |-> $past(wtake, 2) || $past(wtake, 3))
    else $error("irq fell alone");
  cover property (TX_LOAD);
  cover property ($rose(IRQ));
  cover property (take && !HWRITE);
endmodule
bind udbr_top udbr_assertions udbr_assertions_i (.*);

// File: bench/udbr_partner.sv
// far side serial transceiver model
module udbr_partner (
  input wire logic clk,
  input wire logic tx_load,
  input wire logic [8:0] tx_data,
  output logic rx_valid,
  output logic [8:0] rx_data,
  output logic rx_stop1,
  output logic rx_parity_error_flag,
  output logic rx_resp,
  output logic rx_start,
  output logic tx_empty,
  output logic tx_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int shift_cyc = 30;
  int busy = 0;
  int n_got = 0;
  logic [8:0] got = 9'h000;
  initial begin
    rx_valid = 1'b0;
    rx_data = 9'h000;
    rx_stop1 = 1'b1;
    rx_parity_error_flag = 1'b0;
    rx_resp = 1'b0;
    rx_start = 1'b0;
    tx_empty = 1'b1;
    tx_done = 1'b0;
  end
  task automatic send(input logic [8:0] d, input logic s, input logic p,
                      input logic r);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_stop1 <= s;
    rx_parity_error_flag <= p;
    rx_resp <= r;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
  endtask
  task automatic start();
    @(posedge clk);
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
  endtask
  // shifter busy for shift_cyc + 1 cycles per frame
  always @(posedge clk) begin
    tx_done <= 1'b0;
    if (tx_load && tx_empty) begin
      got <= tx_data;
      n_got <= n_got + 1;
      tx_empty <= 1'b0;
      busy <= shift_cyc;
    end else if (!tx_empty) begin
      if (busy == 0) begin
        tx_empty <= 1'b1;
        tx_done <= 1'b1;
      end else begin
        busy <= busy - 1;
      end
    end
  end
endmodule

// File: bench/udbr_tb_top.sv
// self-checking bench for the data buffer block
`include "udbr_defs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module udbr_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] wr;
    logic [7:0] idx;
    logic [15:0] d;
    logic [15:0] e;
  } udbr_row_t;
  udbr_row_t rows [0:22] = '{44'h00000000000, 44'h00100000000,
    44'h00400000020, 44'h00300000000, 44'h10500A50000, 44'h005000000A5,
    44'h10600200000, 44'h00600000000, 44'h108ABCD0000, 44'h0080000ABCD,
    44'h10E00FF0000, 44'h00E0000007F, 44'h10A00550000, 44'h00A00000000,
    44'h10000FF0000, 44'h00000000000, 44'h10500000000,
    44'h10B00FF0000, 44'h00B00000001, 44'h10C00FF0000, 44'h00C00000001,
    44'h10D005A0000, 44'h00D0000005A};
  int error_cnt = 0;
  int n_checks = 0;
  logic clk, nrst, hsel, hwrite, hreadyout, irq, tx_load, rdy_s;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd_s;
  logic [8:0] tx_data, rx_data;
  logic rx_valid, rx_stop1, rx_parity_error_flag, rx_resp, rx_start, tx_empty, tx_done;
  logic hresp;
  logic [7:0] cfg_a, cfg_b, cfg_c, cfg_dbg, cfg_ev, cfg_txpl;
  logic [15:0] cfg_baud;
  logic [6:0] cfg_rxpl;
  udbr_top udbr_top_i (.CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata),
    .HRESP(hresp),
    .RX_CHAR_VALID(rx_valid), .RX_CHAR_DATA(rx_data),
    .RX_CHAR_STOP1(rx_stop1), .RX_CHAR_PARITY_ERROR_FLAG(rx_parity_error_flag),
    .RX_CHAR_RESP(rx_resp), .RX_START_DET(rx_start),
    .TX_SHIFT_EMPTY(tx_empty), .TX_SHIFT_DONE(tx_done), .TX_LOAD(tx_load),
    .TX_DATA(tx_data), .CFG_INTERRUPT_AND_LINE_CONTROL(cfg_a), .CFG_ENABLE_AND_RECEIVE_MODE_CONTROL(cfg_b),
    .CFG_FRAME_FORMAT_CONTROL(cfg_c), .CFG_BAUD(cfg_baud), .CFG_DBG(cfg_dbg),
    .CFG_EVENT_INPUT_CONTROL(cfg_ev), .CFG_TXPL(cfg_txpl), .CFG_RXPL(cfg_rxpl),
    .IRQ(irq));
  udbr_partner p (.clk(clk), .tx_load(tx_load), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_stop1(rx_stop1),
    .rx_parity_error_flag(rx_parity_error_flag), .rx_resp(rx_resp), .rx_start(rx_start),
    .tx_empty(tx_empty), .tx_done(tx_done));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // mid-cycle copies, stable at the next rising edge
  always @(negedge clk) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end
  task automatic bus(input logic w, input logic [4:0] i,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {25'h0000000, i, 2'h0};
    do @(posedge clk); while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy_s !== 1'b1);
    r = rd_s;
  endtask
  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
  endtask
  task automatic rdc(input logic [4:0] i, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, i, 32'h00000000, r);
    `CHK(r, e)
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[k]) begin
      if (rows[k].wr[0])
        wr(rows[k].idx[4:0], {16'h0000, rows[k].d});
      else
        rdc(rows[k].idx[4:0], {16'h0000, rows[k].e});
    end
    `CHK({cfg_a, cfg_b, cfg_c}, 24'h000000)
    `CHK({cfg_dbg, cfg_ev, cfg_txpl}, 24'h01015A)
    `CHK({cfg_baud, cfg_rxpl, hresp}, 24'hABCDFE)
    wr(`UDBR_IDX_IRQ_MASK, 32'h00000001);
    wr(`UDBR_IDX_CTRL_C, 32'h00000017);
    wr(`UDBR_IDX_CTRL_B, 32'h00000080);
    p.send(9'h1A5, 1'b0, 1'b1, 1'b0);
    p.send(9'h05A, 1'b1, 1'b0, 1'b0);
    p.send(9'h033, 1'b1, 1'b0, 1'b0);
    p.start();
    @(negedge clk);
    `CHK(irq, 1'b1)
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000087);
    rdc(`UDBR_IDX_RX_LOW, 32'h000000A5);
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000080);
    rdc(`UDBR_IDX_RX_LOW, 32'h0000005A);
    rdc(`UDBR_IDX_RX_HIGH, 32'h000000C0);
    rdc(`UDBR_IDX_RX_LOW, 32'h00000033);
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000000);
    rdc(`UDBR_IDX_IRQ_STATUS, 32'h00000003);
    wr(`UDBR_IDX_IRQ_STATUS, 32'h0000000F);
    @(negedge clk);
    `CHK(irq, 1'b0)
    wr(`UDBR_IDX_CTRL_C, 32'h00000000);
    p.send(9'h0FF, 1'b1, 1'b1, 1'b0);
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000080);
    rdc(`UDBR_IDX_RX_LOW, 32'h0000001F);
    p.send(9'h011, 1'b0, 1'b0, 1'b0);
    wr(`UDBR_IDX_CTRL_B, 32'h00000000);
    wr(`UDBR_IDX_CTRL_B, 32'h00000080);
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000000);
    wr(`UDBR_IDX_CTRL_C, 32'h00000013);
    wr(`UDBR_IDX_CTRL_B, 32'h00000086);
    p.send(9'h0C1, 1'b1, 1'b1, 1'b0);
    p.send(9'h022, 1'b1, 1'b0, 1'b1);
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000082);
    rdc(`UDBR_IDX_RX_LOW, 32'h000000C1);
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000081);
    `CHK({cfg_b, cfg_c}, 16'h8613)
    wr(`UDBR_IDX_CTRL_B, 32'h00000000);
    wr(`UDBR_IDX_CTRL_C, 32'h00000006);
    wr(`UDBR_IDX_CTRL_B, 32'h00000080);
    p.send(9'h1A5, 1'b0, 1'b1, 1'b0);
    rdc(`UDBR_IDX_RX_LOW, 32'h000000A5);
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000085);
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000000);
    wr(`UDBR_IDX_CTRL_C, 32'h000000F7);
    p.send(9'h1A5, 1'b0, 1'b1, 1'b0);
    rdc(`UDBR_IDX_RX_HIGH, 32'h00000081);
    wr(`UDBR_IDX_CTRL_B, 32'h00000040);
    wr(`UDBR_IDX_CTRL_C, 32'h00000007);
    wr(`UDBR_IDX_TX_HIGH, 32'h00000001);
    wr(`UDBR_IDX_TX_LOW, 32'h0000003C);
    repeat (3) @(negedge clk);
    `CHK(p.got, 9'h13C)
    wr(`UDBR_IDX_TX_LOW, 32'h00000055);
    rdc(`UDBR_IDX_STATUS, 32'h00000000);
    wr(`UDBR_IDX_TX_LOW, 32'h00000066);
    rdc(`UDBR_IDX_TX_LOW, 32'h00000055);
    repeat (80) @(negedge clk);
    `CHK(p.got[7:0], 8'h55)
    wr(`UDBR_IDX_CTRL_C, 32'h00000000);
    wr(`UDBR_IDX_TX_LOW, 32'h000000FF);
    repeat (3) @(negedge clk);
    `CHK(p.got, 9'h01F)
    wr(`UDBR_IDX_CTRL_C, 32'h000000C7);
    repeat (40) @(negedge clk);
    wr(`UDBR_IDX_TX_HIGH, 32'h00000001);
    wr(`UDBR_IDX_TX_LOW, 32'h00000001);
    repeat (3) @(negedge clk);
    `CHK(p.got, 9'h001)
    wr(`UDBR_IDX_CTRL_C, 32'h00000006);
    repeat (40) @(negedge clk);
    wr(`UDBR_IDX_TX_LOW, 32'h0000002B);
    repeat (3) @(negedge clk);
    `CHK(p.n_got, 4)
    wr(`UDBR_IDX_TX_HIGH, 32'h00000001);
    repeat (3) @(negedge clk);
    `CHK(p.got, 9'h12B)
    repeat (40) @(negedge clk);
    wr(`UDBR_IDX_IRQ_MASK, 32'h00000004);
    @(negedge clk);
    `CHK(irq, 1'b1)
    // mid-run reset
    @(posedge clk);
    nrst <= 1'b0;
    @(negedge clk);
    `CHK({irq, hrdata, tx_data}, 42'h00000000000)
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(`UDBR_IDX_STATUS, 32'h00000020);
    rdc(`UDBR_IDX_IRQ_MASK, 32'h00000000);
    `CHK(cfg_c, 8'h00)
    complete_run();
  end
endmodule

// File: common/udbr_defs.vh
// constants for the serial port data buffer and register block
`ifndef UDBR_DEFS_VH
`define UDBR_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define UDBR_IDX_RX_LOW 5'h00
`define UDBR_IDX_RX_HIGH 5'h01
`define UDBR_IDX_TX_LOW 5'h02
`define UDBR_IDX_TX_HIGH 5'h03
`define UDBR_IDX_STATUS 5'h04
`define UDBR_IDX_CTRL_A 5'h05
`define UDBR_IDX_CTRL_B 5'h06
`define UDBR_IDX_CTRL_C 5'h07
`define UDBR_IDX_BAUD 5'h08
`define UDBR_IDX_DBG 5'h0B
`define UDBR_IDX_EVENT_INPUT_CONTROL 5'h0C
`define UDBR_IDX_TXPL 5'h0D
`define UDBR_IDX_RXPL 5'h0E
`define UDBR_IDX_IRQ_STATUS 5'h10
`define UDBR_IDX_IRQ_MASK 5'h11

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UDBR_ST_RXC 7
`define UDBR_ST_TXC 6
`define UDBR_ST_DRE 5
`define UDBR_CB_RECEIVER_ENABLE 7
`define UDBR_CB_TXEN 6
`define UDBR_CB_RXMODE_HI 2
`define UDBR_CB_RXMODE_LO 1
`define UDBR_CC_CMODE_HI 7
`define UDBR_CC_CMODE_LO 6
`define UDBR_CC_PMODE_HI 5
`define UDBR_CC_PMODE_LO 4
`define UDBR_CC_CHARACTER_SIZE_HI 2
`define UDBR_CC_CHARACTER_SIZE_LO 0
`define UDBR_IRQ_RX 0
`define UDBR_IRQ_OVF 1
`define UDBR_IRQ_DRE 2
`define UDBR_IRQ_TXC 3

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define UDBR_CHARACTER_SIZE_5 3'h0
`define UDBR_CHARACTER_SIZE_6 3'h1
`define UDBR_CHARACTER_SIZE_7 3'h2
`define UDBR_CHARACTER_SIZE_9_LOW 3'h6
`define UDBR_CHARACTER_SIZE_9_HIGH 3'h7
`define UDBR_CMODE_MSPI 2'h3
`define UDBR_PMODE_OFF 2'h0
`define UDBR_RXMODE_LIN 2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UDBR_RST_BYTE 8'h00
`define UDBR_RST_BAUD 16'h0000
`define UDBR_RST_IRQ 4'h0
`define UDBR_RST_ENTRY 12'h000

`endif

// File: hdl/udbr_rxfifo.v
// two-entry receive queue with registered head entry
module udbr_rxfifo (
  input wire clk,
  input wire nrst,
  input wire flush,
  input wire push,
  input wire [11:0] push_data,
  input wire pop,
  output wire [11:0] head,
  output wire [1:0] count
);

`include "udbr_defs.vh"

  reg [23:0] ent_q;
  wire [23:0] ent_d;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  wire do_pop;
  wire [1:0] wpos;

  assign do_pop = pop && (cnt_q != 2'h0);
  assign wpos = do_pop ? (cnt_q - 2'h1) : cnt_q;

  // ----------------------------------------------------------------
  // per-entry next value
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ent
      wire [11:0] upper;
      if (i == 0) begin : g_lo
        assign upper = ent_q[23:12];
      end else begin : g_hi
        assign upper = `UDBR_RST_ENTRY;
      end
      assign ent_d[i*12 +: 12] =
        (push && (wpos == i)) ? push_data :
        (do_pop ? upper : ent_q[i*12 +: 12]);
    end
  endgenerate

  always @* begin
    cnt_d = cnt_q;
    if (flush) begin
      cnt_d = 2'h0;
    end else if (push && !do_pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (do_pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ent_q <= {`UDBR_RST_ENTRY, `UDBR_RST_ENTRY};
      cnt_q <= 2'h0;
    end else begin
      ent_q <= flush ? {`UDBR_RST_ENTRY, `UDBR_RST_ENTRY} : ent_d;
      cnt_q <= cnt_d;
    end
  end

  assign head = ent_q[11:0];
  assign count = cnt_q;

endmodule

// File: hdl/udbr_top.v
// serial port data buffers, flags and register file on AHB-Lite
//
// Summary of operation
// - two-deep receive queue advances on data reads
// - receive complete flag means queue not empty
// - overrun: queue full, char waiting, new start
// - master SPI masks overrun, framing, parity flags
// - framing error from first stop bit only
// - parity error only when parity checking enabled or in LIN mode
// - LIN mode parity reports identifier check
// - LIN ninth bit: identifier zero, response one
// - low byte write accepted only when empty
// - buffer moves to shifter when enabled, empty, and no high byte is pending
// - short characters: upper bits dropped, read zero
// - low byte write clears empty flag, set at reset
// - receiver disable flushes queue and error flags
//
// Our own choice: register access over AHB-Lite.
module udbr_top (
  input wire CLK,
  input wire NRST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output reg [31:0] HRDATA,
  output wire HRESP,
  input wire RX_CHAR_VALID,
  input wire [8:0] RX_CHAR_DATA,
  input wire RX_CHAR_STOP1,
  input wire RX_CHAR_PARITY_ERROR_FLAG,
  input wire RX_CHAR_RESP,
  input wire RX_START_DET,
  input wire TX_SHIFT_EMPTY,
  input wire TX_SHIFT_DONE,
  output wire TX_LOAD,
  output wire [8:0] TX_DATA,
  output wire [7:0] CFG_INTERRUPT_AND_LINE_CONTROL,
  output wire [7:0] CFG_ENABLE_AND_RECEIVE_MODE_CONTROL,
  output wire [7:0] CFG_FRAME_FORMAT_CONTROL,
  output wire [15:0] CFG_BAUD,
  output wire [7:0] CFG_DBG,
  output wire [7:0] CFG_EVENT_INPUT_CONTROL,
  output wire [7:0] CFG_TXPL,
  output wire [6:0] CFG_RXPL,
  output wire IRQ
);

`include "udbr_defs.vh"

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [7:0] interrupt_and_line_control_q;
  reg [7:0] enable_and_receive_mode_control_q;
  reg [7:0] frame_format_control_q;
  reg [15:0] baud_q;
  reg [7:0] dbg_q;
  reg [7:0] event_input_control_q;
  reg [7:0] txpl_q;
  reg [6:0] rxpl_q;
  reg [3:0] irq_st_q;
  reg [3:0] irq_mask_q;

  wire receiver_enable;
  wire txen;
  wire mspi;
  wire lin;
  wire par_en;
  wire [2:0] character_size;
  wire is9;
  wire low_first;

  assign receiver_enable = enable_and_receive_mode_control_q[`UDBR_CB_RECEIVER_ENABLE];
  assign txen = enable_and_receive_mode_control_q[`UDBR_CB_TXEN];
  assign mspi =
    (frame_format_control_q[`UDBR_CC_CMODE_HI:`UDBR_CC_CMODE_LO] == `UDBR_CMODE_MSPI);
  assign lin =
    (enable_and_receive_mode_control_q[`UDBR_CB_RXMODE_HI:`UDBR_CB_RXMODE_LO] == `UDBR_RXMODE_LIN);
  assign par_en =
    (frame_format_control_q[`UDBR_CC_PMODE_HI:`UDBR_CC_PMODE_LO] != `UDBR_PMODE_OFF);
  assign character_size = frame_format_control_q[`UDBR_CC_CHARACTER_SIZE_HI:`UDBR_CC_CHARACTER_SIZE_LO];
  assign low_first = (character_size == `UDBR_CHARACTER_SIZE_9_LOW);
  assign is9 = low_first || (character_size == `UDBR_CHARACTER_SIZE_9_HIGH);

  // drop bits above the character size
  function [7:0] size_mask;
    input [7:0] d;
    input [2:0] cs;
    begin
      case (cs)
        `UDBR_CHARACTER_SIZE_5: size_mask = d & 8'h1F;
        `UDBR_CHARACTER_SIZE_6: size_mask = d & 8'h3F;
        `UDBR_CHARACTER_SIZE_7: size_mask = d & 8'h7F;
        default: size_mask = d;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave: one wait state on every transfer
  // ----------------------------------------------------------------
  reg dp1_q;
  reg wr_q;
  reg [4:0] idx_q;
  reg mapped_q;
  reg [31:0] rd_d;
  wire take;
  wire wr_now;
  wire rd_now;

  assign take = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = !dp1_q;
  assign HRESP = 1'b0;
  assign wr_now = dp1_q && wr_q && mapped_q;
  assign rd_now = dp1_q && !wr_q && mapped_q;

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dp1_q <= 1'b0;
      wr_q <= 1'b0;
      idx_q <= 5'h00;
      mapped_q <= 1'b0;
    end else begin
      dp1_q <= take;
      if (take) begin
        wr_q <= HWRITE;
        idx_q <= HADDR[6:2];
        mapped_q <= (HADDR[31:7] == 25'h0000000);
      end
    end
  end

  wire wr_txl;
  wire wr_txh;
  wire wr_st;
  wire wr_irq_st;
  assign wr_txl = wr_now && (idx_q == `UDBR_IDX_TX_LOW);
  assign wr_txh = wr_now && (idx_q == `UDBR_IDX_TX_HIGH);
  assign wr_st = wr_now && (idx_q == `UDBR_IDX_STATUS);
  assign wr_irq_st = wr_now && (idx_q == `UDBR_IDX_IRQ_STATUS);

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      interrupt_and_line_control_q <= `UDBR_RST_BYTE;
      enable_and_receive_mode_control_q <= `UDBR_RST_BYTE;
      frame_format_control_q <= `UDBR_RST_BYTE;
      baud_q <= `UDBR_RST_BAUD;
      dbg_q <= `UDBR_RST_BYTE;
      event_input_control_q <= `UDBR_RST_BYTE;
      txpl_q <= `UDBR_RST_BYTE;
      rxpl_q <= 7'h00;
      irq_mask_q <= `UDBR_RST_IRQ;
    end else if (wr_now) begin
      case (idx_q)
        `UDBR_IDX_CTRL_A: interrupt_and_line_control_q <= HWDATA[7:0];
        `UDBR_IDX_CTRL_B: enable_and_receive_mode_control_q <= HWDATA[7:0] & 8'hDF;
        `UDBR_IDX_CTRL_C: frame_format_control_q <= HWDATA[7:0];
        `UDBR_IDX_BAUD: baud_q <= HWDATA[15:0];
        `UDBR_IDX_DBG: dbg_q <= HWDATA[7:0] & 8'h01;
        `UDBR_IDX_EVENT_INPUT_CONTROL: event_input_control_q <= HWDATA[7:0] & 8'h01;
        `UDBR_IDX_TXPL: txpl_q <= HWDATA[7:0];
        `UDBR_IDX_RXPL: rxpl_q <= HWDATA[6:0];
        `UDBR_IDX_IRQ_MASK: irq_mask_q <= HWDATA[3:0];
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  reg wait_vld_q;
  reg [11:0] wait_q;
  wire [11:0] head;
  wire [1:0] count;
  wire rd_rxl;
  wire rd_rxh;
  wire pop;
  wire space;
  wire push;
  wire [11:0] push_data;
  wire [11:0] inc_entry;
  wire inc_framing_error_flag;
  wire inc_parity_error_flag;
  wire inc_d8;
  wire ovf_evt;
  wire flush;

  assign flush = !receiver_enable;
  assign rd_rxl = rd_now && (idx_q == `UDBR_IDX_RX_LOW);
  assign rd_rxh = rd_now && (idx_q == `UDBR_IDX_RX_HIGH);
  // advance on the second read of the pair
  assign pop = low_first ? rd_rxh : rd_rxl;
  assign space = (count != 2'h2) || pop;

  // first stop bit only, stop-bit count setting not consulted
  assign inc_framing_error_flag = !RX_CHAR_STOP1 && !mspi;
  assign inc_parity_error_flag = !mspi && (lin || par_en) && RX_CHAR_PARITY_ERROR_FLAG;
  assign inc_d8 = lin ? RX_CHAR_RESP : (is9 && RX_CHAR_DATA[8]);
  assign inc_entry = {1'b0, inc_framing_error_flag, inc_parity_error_flag, inc_d8,
                      size_mask(RX_CHAR_DATA[7:0], character_size)};

  assign ovf_evt = receiver_enable && !mspi && RX_START_DET && wait_vld_q &&
                   (count == 2'h2);
  assign push = receiver_enable && space && (wait_vld_q || RX_CHAR_VALID);
  // a start seen while the waiting char moves in still marks it
  assign push_data = wait_vld_q ? {wait_q[11] || ovf_evt, wait_q[10:0]} :
                     inc_entry;

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wait_vld_q <= 1'b0;
      wait_q <= `UDBR_RST_ENTRY;
    end else if (flush) begin
      wait_vld_q <= 1'b0;
      wait_q <= `UDBR_RST_ENTRY;
    end else if (wait_vld_q && push) begin
      wait_vld_q <= RX_CHAR_VALID;
      wait_q <= inc_entry;
    end else if (RX_CHAR_VALID && !push) begin
      // lost character keeps the overrun mark of the one it replaces
      wait_vld_q <= 1'b1;
      wait_q <= {(wait_vld_q && wait_q[11]) || ovf_evt, inc_entry[10:0]};
    end else if (ovf_evt) begin
      wait_q[11] <= 1'b1;
    end
  end

  udbr_rxfifo u_rxfifo (
    .clk(CLK),
    .nrst(NRST),
    .flush(flush),
    .push(push),
    .push_data(push_data),
    .pop(pop),
    .head(head),
    .count(count)
  );

  wire receive_complete_flag;
  assign receive_complete_flag = (count != 2'h0);

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  reg [7:0] txb_q;
  reg tx9_q;
  reg data_register_empty_flag_q;
  reg hi_pend_q;
  reg txcif_q;
  wire tx_ok_low;
  wire tx_ok_high;
  wire txc_evt;

  assign tx_ok_low = wr_txl && data_register_empty_flag_q;
  assign tx_ok_high = wr_txh && (data_register_empty_flag_q || hi_pend_q);
  assign TX_LOAD = !data_register_empty_flag_q && txen && TX_SHIFT_EMPTY &&
                   !hi_pend_q;
  assign TX_DATA = {tx9_q && is9 && !mspi, txb_q};
  assign txc_evt = TX_SHIFT_DONE && (data_register_empty_flag_q || TX_LOAD);

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      txb_q <= `UDBR_RST_BYTE;
      tx9_q <= 1'b0;
      data_register_empty_flag_q <= 1'b1;
      hi_pend_q <= 1'b0;
      txcif_q <= 1'b0;
    end else begin
      if (tx_ok_low) begin
        txb_q <= size_mask(HWDATA[7:0], character_size);
        data_register_empty_flag_q <= 1'b0;
        hi_pend_q <= low_first;
      end else if (TX_LOAD) begin
        data_register_empty_flag_q <= 1'b1;
      end
      if (tx_ok_high) begin
        tx9_q <= HWDATA[0];
        if (!tx_ok_low) begin
          hi_pend_q <= 1'b0;
        end
      end
      // set wins over a write-one clear
      if (txc_evt) begin
        txcif_q <= 1'b1;
      end else if (wr_st && HWDATA[`UDBR_ST_TXC]) begin
        txcif_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------------------------------
  wire [3:0] irq_evt;
  assign irq_evt[`UDBR_IRQ_RX] = push;
  assign irq_evt[`UDBR_IRQ_OVF] = ovf_evt;
  assign irq_evt[`UDBR_IRQ_DRE] = TX_LOAD;
  assign irq_evt[`UDBR_IRQ_TXC] = txc_evt;

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_st_q <= `UDBR_RST_IRQ;
    end else begin
      irq_st_q <= (irq_st_q & ~(wr_irq_st ? HWDATA[3:0] : 4'h0)) |
                  irq_evt;
    end
  end

  assign IRQ = |(irq_st_q & irq_mask_q);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @* begin
    rd_d = 32'h00000000;
    case (idx_q)
      `UDBR_IDX_RX_LOW: rd_d[7:0] = head[7:0];
      `UDBR_IDX_RX_HIGH: rd_d[7:0] = {receive_complete_flag, head[11] && receive_complete_flag, 3'h0,
                                      head[10] && receive_complete_flag,
                                      head[9] && receive_complete_flag, head[8]};
      `UDBR_IDX_TX_LOW: rd_d[7:0] = txb_q;
      `UDBR_IDX_STATUS: rd_d[7:0] = {receive_complete_flag, txcif_q, data_register_empty_flag_q, 5'h00};
      `UDBR_IDX_CTRL_A: rd_d[7:0] = interrupt_and_line_control_q;
      `UDBR_IDX_CTRL_B: rd_d[7:0] = enable_and_receive_mode_control_q;
      `UDBR_IDX_CTRL_C: rd_d[7:0] = frame_format_control_q;
      `UDBR_IDX_BAUD: rd_d[15:0] = baud_q;
      `UDBR_IDX_DBG: rd_d[7:0] = dbg_q;
      `UDBR_IDX_EVENT_INPUT_CONTROL: rd_d[7:0] = event_input_control_q;
      `UDBR_IDX_TXPL: rd_d[7:0] = txpl_q;
      `UDBR_IDX_RXPL: rd_d[6:0] = rxpl_q;
      `UDBR_IDX_IRQ_STATUS: rd_d[3:0] = irq_st_q;
      `UDBR_IDX_IRQ_MASK: rd_d[3:0] = irq_mask_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      HRDATA <= 32'h00000000;
    end else if (rd_now) begin
      HRDATA <= rd_d;
    end else if (dp1_q) begin
      HRDATA <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  assign CFG_INTERRUPT_AND_LINE_CONTROL = interrupt_and_line_control_q;
  assign CFG_ENABLE_AND_RECEIVE_MODE_CONTROL = enable_and_receive_mode_control_q;
  assign CFG_FRAME_FORMAT_CONTROL = frame_format_control_q;
  assign CFG_BAUD = baud_q;
  assign CFG_DBG = dbg_q;
  assign CFG_EVENT_INPUT_CONTROL = event_input_control_q;
  assign CFG_TXPL = txpl_q;
  assign CFG_RXPL = rxpl_q;

endmodule
